// [timer16_counter_input_capture.sv]
// Sixteen-bit up/down counter with input capture behind an AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

// What this block does
// (R1) High-byte access uses staging; low read latches high
// (R2) Low-byte counter write loads full sixteen bits
// (R3) One shared staging byte keeps its value
// (R4) Three-bit clock select; zero stops counting
// (R5) Each tick clears or steps count by one, dual-slope turns at top and bottom included
// (R6) Software counter write beats clear and count
// (R7) Four-bit waveform mode split over control A, B
// (R8) Bottom at zero, top at sequence maximum
// (R9) Overflow flag set where mode defines; requests interrupt
// (R10) Selected trigger edge copies count into capture
// (R11) Capture flag set in the copy cycle
// (R12) Enabled capture flag requests interrupt; ack clears
// (R13) Writing one clears capture flag; zero keeps
// (R14) Capture low read first latches high into staging
// (R15) Capture writable only in capture-top modes
// (R16) Software writes capture high before low
// (R17) Comparator select switches trigger to comparator output
// (R18) Source switch may capture; software clears flag
// (R19) Filter passes level after four equal samples
// (R20) Filter enable adds four cycles, prescaler independent
// (R21) No captures in capture-top modes
// (R22) Software toggling capture pin triggers captures
// (R23) Top fixed, compare A, or capture per mode
// (R24) Count maximum all ones, bottom zero
// (R25) Edge select picks rising or falling trigger
// (R26) Capture and comparator inputs synchronised first
module timer16_counter_input_capture
  import timer16_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] prescale_taps,
  input wire logic external_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic [15:0] compare_a_value,
  input wire logic capture_irq_ack,
  input wire logic overflow_irq_ack,
  output logic [15:0] count_value,
  output logic [3:0] waveform_mode_field,
  output logic count_top,
  output logic count_bottom,
  output logic count_down,
  output logic capture_irq,
  output logic overflow_irq
);

  // ----------------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------------
  // Modes that take their top from the capture register
  function automatic logic uses_capture_top(input logic [3:0] m);
    return (m == 4'd8) || (m == 4'd10) || (m == 4'd12) || (m == 4'd14);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] control_a_r, control_b_r, comp_ctrl_r, irq_enable_r, staging_r;
  logic [15:0] count_r, capture_r;
  logic dir_down_r, overflow_flag_r, capture_flag_r;
  logic cap_s1_r, cap_s2_r, comp_s1_r, comp_s2_r, ext_s1_r, ext_s2_r, ext_prev_r;
  logic [3:0] filt_hist_r;
  logic filt_level_r, edge_prev_r;
  logic aw_got_r, w_got_r, wstrb0_r, bvalid_r, rvalid_r;
  logic [7:0] waddr_r, wdata_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r, bresp_r;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  wire [3:0] wgm = {control_b_r[CTRLB_WGM_HI_LO +: 2], control_a_r[CTRLA_WGM_LO +: 2]}; // R7
  wire [2:0] clock_source_select = control_b_r[CTRLB_CS_LO +: 3];
  wire edge_rising = control_b_r[CTRLB_EDGE_RISE];
  wire noise_filter_enable = control_b_r[CTRLB_FILTER_EN];
  wire comparator_trigger_select = comp_ctrl_r[COMP_TRIGGER_SEL];
  wire capture_irq_enable = irq_enable_r[FLAG_CAPTURE];
  wire overflow_irq_enable = irq_enable_r[FLAG_OVERFLOW];
  wire capture_top_mode = uses_capture_top(wgm);

  // ----------------------------------------------------------------------
  // Timer tick selection
  // ----------------------------------------------------------------------
  wire ext_rise = ext_s2_r & ~ext_prev_r;
  wire ext_fall = ~ext_s2_r & ext_prev_r;
  logic timer_tick;
  always_comb begin
    unique case (clock_source_select) // R4
      CS_STOP: timer_tick = 1'b0;
      CS_DIV1: timer_tick = 1'b1;
      CS_DIV8: timer_tick = prescale_taps[0];
      CS_DIV64: timer_tick = prescale_taps[1];
      CS_DIV256: timer_tick = prescale_taps[2];
      CS_DIV1024: timer_tick = prescale_taps[3];
      CS_EXT_FALL: timer_tick = ext_fall;
      CS_EXT_RISE: timer_tick = ext_rise;
    endcase
  end

  // ----------------------------------------------------------------------
  // Top value and sequence shape
  // ----------------------------------------------------------------------
  logic [15:0] top_value;
  logic dual_slope, clear_at_top, ovf_at_top;
  always_comb begin
    top_value = COUNT_MAX;
    dual_slope = 1'b0;
    clear_at_top = 1'b0;
    ovf_at_top = 1'b0;
    unique case (wgm) // R23
      4'd1, 4'd5: top_value = TOP_8BIT;
      4'd2, 4'd6: top_value = TOP_9BIT;
      4'd3, 4'd7: top_value = TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15: top_value = compare_a_value;
      4'd8, 4'd10, 4'd12, 4'd14: top_value = capture_r;
      default: top_value = COUNT_MAX; // R24
    endcase
    unique case (wgm)
      4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: dual_slope = 1'b1;
      4'd4, 4'd12: clear_at_top = 1'b1;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15: begin
        clear_at_top = 1'b1;
        ovf_at_top = 1'b1;
      end
      default: dual_slope = 1'b0;
    endcase
  end

  wire at_top = (count_r == top_value);
  wire at_bottom = (count_r == COUNT_BOTTOM);
  // Next count on a tick: clear, or step by one, also from bottom up to one while turning up in dual slope
  logic [15:0] tick_count;
  logic tick_down, tick_ovf;
  always_comb begin
    tick_count = count_r + COUNT_ONE;
    tick_down = dir_down_r;
    tick_ovf = 1'b0;
    if (dual_slope) begin
      if (dir_down_r) begin
        if (at_bottom) tick_down = 1'b0;
        else tick_count = count_r - COUNT_ONE;
        tick_ovf = at_bottom; // R9
      end else if (count_r >= top_value) begin
        tick_down = 1'b1;
        tick_count = count_r - COUNT_ONE;
      end
    end else begin
      tick_down = 1'b0;
      if (clear_at_top && at_top) tick_count = COUNT_BOTTOM; // R5
      tick_ovf = ovf_at_top ? at_top : (count_r == COUNT_MAX); // R9
    end
  end

  // ----------------------------------------------------------------------
  // Capture trigger path: sync, source select, filter, edge detect
  // ----------------------------------------------------------------------
  wire trig_raw = comparator_trigger_select ? comp_s2_r : cap_s2_r; // R17
  wire [3:0] filt_window = {filt_hist_r[2:0], trig_raw};
  wire filt_all_one = &filt_window[FILTER_SAMPLES-1:0];
  wire filt_all_zero = ~|filt_window[FILTER_SAMPLES-1:0];
  wire filt_next = filt_all_one ? 1'b1 : (filt_all_zero ? 1'b0 : filt_level_r); // R19
  wire edge_in = noise_filter_enable ? filt_level_r : trig_raw; // R20
  wire edge_seen = edge_rising ? (edge_in & ~edge_prev_r) : (~edge_in & edge_prev_r); // R25
  wire capture_event = edge_seen & ~capture_top_mode; // R21

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready = ~w_got_r & ~bvalid_r;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_got_r & w_got_r & ~bvalid_r;
  wire wr_en = wr_go & wstrb0_r;
  wire [7:0] wb = wdata_r;
  wire wr_ctrl_a = wr_en & (waddr_r == OFS_CONTROL_A);
  wire wr_ctrl_b = wr_en & (waddr_r == OFS_CONTROL_B);
  wire wr_cnt_lo = wr_en & (waddr_r == OFS_COUNT_LOW);
  wire wr_cap_lo = wr_en & (waddr_r == OFS_CAPTURE_LOW) & capture_top_mode; // R15
  wire wr_high = wr_en & ((waddr_r == OFS_COUNT_HIGH) | (waddr_r == OFS_CAPTURE_HIGH)); // R1
  wire wr_flags = wr_en & (waddr_r == OFS_FLAGS);
  wire wr_irq_en = wr_en & (waddr_r == OFS_IRQ_ENABLE);
  wire wr_comp = wr_en & (waddr_r == OFS_COMP_CTRL);
  wire waddr_ok = (waddr_r <= OFS_COMP_CTRL) & (waddr_r[1:0] == 2'b00);

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = ~rvalid_r;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire rd_cnt_lo = ar_fire & (s_axi_araddr == OFS_COUNT_LOW);
  wire rd_cap_lo = ar_fire & (s_axi_araddr == OFS_CAPTURE_LOW);
  wire [7:0] flags_byte = 8'(overflow_flag_r) << FLAG_OVERFLOW |
                          8'(capture_flag_r) << FLAG_CAPTURE;
  logic [7:0] rd_byte;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFS_CONTROL_A: rd_byte = control_a_r;
      OFS_CONTROL_B: rd_byte = control_b_r;
      OFS_COUNT_LOW: rd_byte = count_r[7:0];
      OFS_COUNT_HIGH: rd_byte = staging_r; // R1
      OFS_CAPTURE_LOW: rd_byte = capture_r[7:0];
      OFS_CAPTURE_HIGH: rd_byte = staging_r; // R14
      OFS_FLAGS: rd_byte = flags_byte;
      OFS_IRQ_ENABLE: rd_byte = irq_enable_r;
      OFS_COMP_CTRL: rd_byte = comp_ctrl_r;
      default: begin
        rd_byte = RST_BYTE;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= RST_BYTE;
      wdata_r <= RST_BYTE;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_got_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
      end else if (s_axi_bready) bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (wr_go) bresp_r <= waddr_ok ? RESP_OKAY : RESP_SLVERR;
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, rd_byte};
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers and shared staging byte
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_a_r <= RST_BYTE;
      control_b_r <= RST_BYTE;
      comp_ctrl_r <= RST_BYTE;
      irq_enable_r <= RST_BYTE;
      staging_r <= RST_BYTE;
    end else begin
      if (wr_ctrl_a) control_a_r <= wb;
      if (wr_ctrl_b) control_b_r <= wb;
      if (wr_comp) comp_ctrl_r <= wb;
      if (wr_irq_en) irq_enable_r <= wb;
      // Bus write wins a collision with a low-byte read latch
      if (wr_high) staging_r <= wb; // R3
      else if (rd_cnt_lo) staging_r <= count_r[15:8]; // R1
      else if (rd_cap_lo) staging_r <= capture_r[15:8]; // R14
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= RST_WORD;
      dir_down_r <= 1'b0;
    end else if (wr_cnt_lo) begin
      count_r <= {staging_r, wb}; // R2 R6
    end else if (timer_tick) begin
      count_r <= tick_count; // R5
      dir_down_r <= tick_down;
    end
  end

  // ----------------------------------------------------------------------
  // Capture register and flags
  // ----------------------------------------------------------------------
  wire ovf_set = timer_tick & ~wr_cnt_lo & tick_ovf;
  wire ovf_clr = (wr_flags & wb[FLAG_OVERFLOW]) | overflow_irq_ack;
  wire cap_clr = (wr_flags & wb[FLAG_CAPTURE]) | capture_irq_ack; // R13 R12
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_r <= RST_WORD;
      capture_flag_r <= 1'b0;
      overflow_flag_r <= 1'b0;
    end else begin
      if (capture_event) capture_r <= count_r; // R10 R22
      else if (wr_cap_lo) capture_r <= {staging_r, wb};
      // A new event outranks a clear in the same cycle
      if (capture_event) capture_flag_r <= 1'b1; // R11 R18
      else if (cap_clr) capture_flag_r <= 1'b0;
      if (ovf_set) overflow_flag_r <= 1'b1; // R9
      else if (ovf_clr) overflow_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and filter
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      cap_s1_r <= capture_pin; // R26
      cap_s2_r <= cap_s1_r;
      comp_s1_r <= comparator_output; // R26
      comp_s2_r <= comp_s1_r;
      ext_s1_r <= external_count_pin;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  // Filter history runs in every mode so that re-enabling it sees fresh samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_hist_r <= RST_FILTER;
      filt_level_r <= 1'b0;
      edge_prev_r <= 1'b0;
    end else begin
      filt_hist_r <= filt_window;
      filt_level_r <= filt_next; // R19
      edge_prev_r <= edge_in;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign count_value = count_r;
  assign waveform_mode_field = wgm;
  assign count_top = at_top; // R8
  assign count_bottom = at_bottom; // R8
  assign count_down = dir_down_r;
  assign capture_irq = capture_flag_r & capture_irq_enable; // R12
  assign overflow_irq = overflow_flag_r & overflow_irq_enable; // R9

endmodule

// [timer16_pkg.sv]
// Constants shared by the sixteen-bit timer counter with input capture
package timer16_pkg;

  // ----------
  // Register byte addresses (one aligned word each, data in bits 7:0)
  // ----------
  localparam logic [7:0] OFS_CONTROL_A = 8'h00;
  localparam logic [7:0] OFS_CONTROL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h0c;
  localparam logic [7:0] OFS_CAPTURE_LOW = 8'h10;
  localparam logic [7:0] OFS_CAPTURE_HIGH = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h20;

  // ----------
  // Field positions
  // ----------
  localparam int CTRLA_WGM_LO = 0;
  localparam int CTRLB_CS_LO = 0;
  localparam int CTRLB_WGM_HI_LO = 3;
  localparam int CTRLB_EDGE_RISE = 6;
  localparam int CTRLB_FILTER_EN = 7;
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_CAPTURE = 5;
  localparam int COMP_TRIGGER_SEL = 2;

  // ----------
  // Reset values
  // ----------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_FILTER = 4'h0;

  // ----------
  // Count limits and fixed tops
  // ----------
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // Noise filter depth in system clock samples
  localparam int FILTER_SAMPLES = 4;

  // ----------
  // Clock source codes
  // ----------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// [timer16_prescaler_model.sv]
// Prescaler partner that feeds one-cycle divider taps to the timer
`timescale 1ns/1ps
module timer16_prescaler_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [3:0] prescale_taps
);
  logic [9:0] div_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_r + 10'h001;
    end
  end
  // One pulse per wrap of each ratio; when div_r is 3ff all four taps pulse in the same cycle
  assign prescale_taps = {div_r == 10'h3ff, div_r[7:0] == 8'hff, div_r[5:0] == 6'h3f,
    div_r[2:0] == 3'h7};
endmodule

// [timer16_counter_input_capture_assertions.sv]
// Port-level checks for the sixteen-bit timer with input capture
`timescale 1ns/1ps
module timer16_ic_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] compare_a_value,
  input wire logic [15:0] count_value,
  input wire logic [3:0] waveform_mode_field,
  input wire logic count_top,
  input wire logic count_bottom,
  input wire logic capture_irq,
  input wire logic overflow_irq
);
  logic [15:0] fix_top;
  assign fix_top = (waveform_mode_field[1:0] == 2'h1) ? 16'h00ff :
    (waveform_mode_field[1:0] == 2'h2) ? 16'h01ff : 16'h03ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bottom; count_bottom == (count_value == 16'h0000); endproperty
  a_bottom: assert property (p_bottom) else $error("bottom flag wrong");
  property p_top_max;
    waveform_mode_field inside {4'h0, 4'hd} |-> count_top == (count_value == 16'hffff);
  endproperty
  a_top_max: assert property (p_top_max) else $error("top not at max");
  property p_top_fix;
    waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}
      |-> count_top == (count_value == fix_top);
  endproperty
  a_top_fix: assert property (p_top_fix) else $error("fixed top wrong");
  property p_top_cmp;
    waveform_mode_field inside {4'h4, 4'h9, 4'hb, 4'hf}
      |-> count_top == (count_value == compare_a_value);
  endproperty
  a_top_cmp: assert property (p_top_cmp) else $error("compare top wrong");
  property p_step;
    waveform_mode_field == 4'h0 ##1 !$rose(s_axi_bvalid)
      |-> count_value inside {$past(count_value), 16'($past(count_value) + 16'h0001)};
  endproperty
  a_step: assert property (p_step) else $error("count step not one");
  property p_ovf;
    $rose(overflow_irq) && !$rose(s_axi_bvalid) && waveform_mode_field == 4'h0
      |-> $past(count_value) == 16'hffff;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow at wrong count");
  property p_cap_mode;
    $rose(capture_irq) && !$rose(s_axi_bvalid)
      |-> !(waveform_mode_field inside {4'h8, 4'ha, 4'hc, 4'he});
  endproperty
  a_cap_mode: assert property (p_cap_mode) else $error("capture in top mode");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read response repeated");
endmodule

bind timer16_counter_input_capture timer16_ic_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .compare_a_value(compare_a_value), .count_value(count_value),
  .waveform_mode_field(waveform_mode_field), .count_top(count_top),
  .count_bottom(count_bottom), .capture_irq(capture_irq), .overflow_irq(overflow_irq));

// [timer16_counter_input_capture_tb.sv]
// Self-checking bench for the sixteen-bit timer with input capture
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module timer16_counter_input_capture_tb
  import timer16_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lo, hi;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, external_count_pin = 1'b0;
  logic capture_pin = 1'b0, comparator_output = 1'b0;
  logic capture_irq_ack = 1'b0, overflow_irq_ack = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] prescale_taps, waveform_mode_field, mv;
  logic [15:0] count_value, wcnt, v;
  logic count_top, count_bottom, count_down, capture_irq, overflow_irq;
  int n_errors = 0, n_tests = 0, n_u, n_f, k;
  always #4 aclk = ~aclk;
  timer16_prescaler_model PRE (.aclk(aclk), .aresetn(aresetn), .prescale_taps(prescale_taps));
  timer16_counter_input_capture DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .prescale_taps(prescale_taps),
    .external_count_pin(external_count_pin), .capture_pin(capture_pin),
    .comparator_output(comparator_output), .compare_a_value(16'h1256),
    .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .count_value(count_value), .waveform_mode_field(waveform_mode_field),
    .count_top(count_top), .count_bottom(count_bottom), .count_down(count_down),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq));
  // ----------
  // Bus and wait tasks
  // ----------
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic timed_out();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    summarize();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // wcnt is the count the write committed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic dn;
    dn = 1'b0;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn && k < 100) begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        dn = 1'b1;
        rsp = s_axi_bresp;
        wcnt = count_value;
        s_axi_bready <= 1'b0;
      end
    end
    if (!dn) timed_out();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic dn;
    dn = 1'b0;
    k = 0;
    d = 8'h00;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn && k < 100) begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dn = 1'b1;
        d = s_axi_rdata[7:0];
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!dn) timed_out();
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] r);
    rd(a, lo);
    rd(a + 8'h04, hi);
    r = {hi, lo};
  endtask
  task automatic wait_cap(output int n);
    n = 0;
    while (!capture_irq && n < 40) begin
      @(posedge aclk);
      n++;
    end
    if (!capture_irq) timed_out();
  endtask
  // ----------
  // Test sequence
  // ----------
  initial begin
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    `CHK(count_value, 16'h0000)
    `CHK(count_bottom, 1'b1)
    `CHK(count_down, 1'b0)
    $display("reset test done");
    wr(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_COUNT_LOW, 8'h34);
    `CHK(count_value, 16'h1234)
    wr(OFS_COUNT_HIGH, 8'h99);
    `CHK(count_value, 16'h1234)
    rd16(OFS_COUNT_LOW, v);
    `CHK(v, 16'h1234)
    wr(OFS_COUNT_LOW, 8'h56);
    `CHK(count_value, 16'h1256)
    tick(20);
    `CHK(count_value, 16'h1256)
    wr(8'h24, 8'h00);
    `CHK(rsp, RESP_SLVERR)
    $display("access test done");
    for (int m = 0; m < 16; m++) begin
      mv = 4'(m);
      wr(OFS_CONTROL_A, {6'h00, mv[1:0]});
      wr(OFS_CONTROL_B, {3'h0, mv[3:2], 3'h0});
      `CHK(waveform_mode_field, mv)
    end
    wr(OFS_CONTROL_A, 8'h00);
    wr(OFS_CONTROL_B, 8'h07);
    for (int i = 0; i < 3; i++) begin
      external_count_pin <= 1'b1;
      tick(4);
      external_count_pin <= 1'b0;
      tick(4);
    end
    tick(4);
    wr(OFS_CONTROL_B, 8'h00);
    `CHK(count_value, 16'h1259)
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_CONTROL_B, 8'h01);
    wr(OFS_COUNT_HIGH, 8'hff);
    wr(OFS_COUNT_LOW, 8'hfd);
    `CHK(wcnt, 16'hfffd)
    n_u = 0;
    while (!overflow_irq && n_u < 20) begin
      @(posedge aclk);
      n_u++;
    end
    if (!overflow_irq) timed_out();
    `CHK(count_value, 16'h0000)
    wr(OFS_CONTROL_B, 8'h00);
    overflow_irq_ack <= 1'b1;
    tick(1);
    overflow_irq_ack <= 1'b0;
    tick(1);
    `CHK(overflow_irq, 1'b0)
    $display("count test done");
    wr(OFS_COUNT_HIGH, 8'h0a);
    wr(OFS_COUNT_LOW, 8'hbc);
    wr(OFS_IRQ_ENABLE, 8'h20);
    wr(OFS_CONTROL_B, 8'h40);
    wr(OFS_FLAGS, 8'h21);
    capture_pin <= 1'b1;
    wait_cap(n_u);
    `CHK(capture_irq, 1'b1)
    rd16(OFS_CAPTURE_LOW, v);
    `CHK(v, 16'h0abc)
    wr(OFS_FLAGS, 8'h00);
    `CHK(capture_irq, 1'b1)
    capture_irq_ack <= 1'b1;
    tick(1);
    capture_irq_ack <= 1'b0;
    tick(1);
    `CHK(capture_irq, 1'b0)
    capture_pin <= 1'b0;
    tick(20);
    `CHK(capture_irq, 1'b0)
    wr(OFS_CONTROL_B, 8'hc0);
    capture_pin <= 1'b1;
    tick(3);
    capture_pin <= 1'b0;
    tick(20);
    `CHK(capture_irq, 1'b0)
    capture_pin <= 1'b1;
    wait_cap(n_f);
    `CHK(n_f, n_u + 4)
    wr(OFS_FLAGS, 8'h20);
    `CHK(capture_irq, 1'b0)
    capture_pin <= 1'b0;
    tick(20);
    $display("capture test done");
    wr(OFS_COMP_CTRL, 8'h04);
    wr(OFS_FLAGS, 8'h20);
    comparator_output <= 1'b1;
    wait_cap(n_u);
    `CHK(capture_irq, 1'b1)
    wr(OFS_FLAGS, 8'h20);
    wr(OFS_COMP_CTRL, 8'h00);
    wr(OFS_CAPTURE_HIGH, 8'h77);
    wr(OFS_CAPTURE_LOW, 8'h66);
    rd16(OFS_CAPTURE_LOW, v);
    `CHK(v, 16'h0abc)
    wr(OFS_CONTROL_B, 8'hd8);
    wr(OFS_CAPTURE_HIGH, 8'h02);
    wr(OFS_CAPTURE_LOW, 8'h00);
    rd16(OFS_CAPTURE_LOW, v);
    `CHK(v, 16'h0200)
    capture_pin <= 1'b1;
    tick(20);
    `CHK(capture_irq, 1'b0)
    $display("source and top test done");
    summarize();
  end
endmodule
